// File: hdl/swd_pkg.sv
// Overview of operation
// - Watchdog is a 16-bit up-counter ticking every 24, or 384, core clocks.
// - Reset leaves watchdog idle with counter and watchdog registers cleared, except the expiry bit.
// - A running watchdog stops only on the internal reset.
// - Setting the start flag while idle starts the counter; the refresh flag alone does not.
// - Counter reaching 0x7CFF raises expiry, sets priority bit 6, requests reset.
// - Expiry status drops on reset or when the counter moves off 0x7CFF.
// - Refresh flag then start flag within 12 cycles reloads and clears refresh.
// - Refresh flag alone for 12 cycles clears itself without any reload.
// - Refresh flag, first enable register bit 6, self-clears 12 cycles after set.
// - Start flag, second enable register bit 6, self-clears 12 cycles after set.
// - First enable register bit 7 low blocks every interrupt request.
// - First enable bits 0-4 gate ext0, timer0, ext1, timer1, serial0.
// - Second enable bits 1-5 gate external interrupts 2 to 6.
// - Expiry bit in priority register survives watchdog reset; software clears it.
// - Reload register bit 7 adds a divide-by-16 prescaler.
// - Refresh loads reload bits 6-0 into the counter high byte.
package swd_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_RELOAD = 8'h86;
  localparam logic [7:0] ADDR_IRQ_ENABLE_0 = 8'hA8;
  localparam logic [7:0] ADDR_PRIO0 = 8'hA9;
  localparam logic [7:0] ADDR_IRQ_ENABLE_1 = 8'hB8;
  localparam logic [7:0] ADDR_CNT_LO = 8'hF0;
  localparam logic [7:0] ADDR_CNT_HI = 8'hF1;

  // Field positions
  localparam int BIT_GLOBAL_GATE = 7;
  localparam int BIT_REFRESH = 6;
  localparam int BIT_START = 6;
  localparam int BIT_EXPIRED = 6;
  localparam int BIT_PRESCALE_SEL = 7;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;

  // Timing counts
  localparam logic [15:0] EXPIRY_COUNT = 16'h7CFF;
  localparam logic [8:0] PRE_SHORT = 9'h018;
  localparam logic [8:0] PRE_LONG = 9'h180;
  localparam logic [3:0] FLAG_LIFE = 4'hC;

  // Interrupt sources
  localparam int NUM_IRQ = 10;

  // Watchdog run state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } swd_state_t;

  // Address match used for both write and read decode
  function automatic logic swd_hit(input logic [7:0] addr, input logic [7:0] off);
    swd_hit = (addr == off);
  endfunction

endpackage

// File: hdl/swd_pre_if.sv
`timescale 1ns/100ps
// Prescaler control and tick between watchdog core and prescaler
interface swd_pre_if;
  logic run;
  logic clear;
  logic sel_long;
  logic tick;
  modport ctrl (output run, output clear, output sel_long, input tick);
  modport pre (input run, input clear, input sel_long, output tick);
endinterface

// File: hdl/swd_prescaler.sv
`timescale 1ns/100ps
module swd_prescaler (
  input wire logic i_clock,
  input wire logic i_rst,
  swd_pre_if.pre pre
);

  logic [8:0] cnt_ff;
  logic [8:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;
  logic [8:0] last;

  // Next prescaler count and tick
  always_comb begin
    last = pre.sel_long ? swd_pkg::PRE_LONG - 9'h001 : swd_pkg::PRE_SHORT - 9'h001;
    nxt_cnt = cnt_ff;
    nxt_tick = 1'b0;
    if (pre.clear) begin
      nxt_cnt = 9'h000;
    end else if (pre.run) begin
      if (cnt_ff >= last) begin
        nxt_cnt = 9'h000;
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 9'h001;
      end
    end
  end

  // Register prescaler state
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cnt_ff <= 9'h000;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign pre.tick = tick_ff;

endmodule // swd_prescaler

// File: hdl/swd_flag_timer.sv
`timescale 1ns/100ps
module swd_flag_timer (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_set,
  input wire logic i_clear,
  output logic o_flag
);

  logic flag_ff;
  logic nxt_flag;
  logic [3:0] life_ff;
  logic [3:0] nxt_life;

  // Flag stays up for a fixed number of cycles; a new set wins and restarts it
  always_comb begin
    nxt_flag = flag_ff;
    nxt_life = life_ff;
    if (i_set) begin
      nxt_flag = 1'b1;
      nxt_life = swd_pkg::FLAG_LIFE;
    end else if (i_clear) begin
      nxt_flag = 1'b0;
      nxt_life = 4'h0;
    end else if (flag_ff) begin
      nxt_life = life_ff - 4'h1;
      if (life_ff == 4'h1) begin
        nxt_flag = 1'b0;
      end
    end
  end

  // Register flag state
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      flag_ff <= 1'b0;
      life_ff <= 4'h0;
    end else begin
      flag_ff <= nxt_flag;
      life_ff <= nxt_life;
    end
  end

  assign o_flag = flag_ff;

endmodule // swd_flag_timer

// File: hdl/swd_watchdog.sv
// Local design decision: the strobed register port.
`timescale 1ns/100ps
module swd_watchdog (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_por_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [swd_pkg::NUM_IRQ-1:0] i_irq_req,
  output logic [7:0] o_rdata,
  output logic [swd_pkg::NUM_IRQ-1:0] o_irq_gated,
  output logic o_wd_expired_status,
  output logic o_chip_reset_req,
  output logic o_wd_running
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Watchdog core state
  swd_pkg::swd_state_t state_ff;
  swd_pkg::swd_state_t nxt_state;
  logic running_ff;
  logic nxt_running;
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic expired_ff;
  logic nxt_expired;
  logic reset_req_ff;
  logic nxt_reset_req;

  // Software-visible fields
  logic prio_expired_ff;
  logic nxt_prio_expired;
  logic [5:0] prio_low_ff;
  logic [5:0] nxt_prio_low;
  logic [7:0] reload_ff;
  logic [7:0] nxt_reload;
  logic [6:0] irq_enable_0_ff;
  logic [6:0] nxt_irq_enable_0;
  logic [4:0] irq_enable_1_ff;
  logic [4:0] nxt_irq_enable_1;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  // Interrupt gating
  logic [swd_pkg::NUM_IRQ-1:0] irq_ff;
  logic [swd_pkg::NUM_IRQ-1:0] nxt_irq;
  logic [swd_pkg::NUM_IRQ-1:0] irq_enable;

  // Bus decode, handshake flags and prescaler link
  logic wr_reload;
  logic wr_prio;
  logic wr_irq_enable_0;
  logic wr_irq_enable_1;
  logic set_refresh;
  logic set_start;
  logic refresh_flag;
  logic start_flag;
  logic do_refresh;
  swd_pre_if pre_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // Write decode and flag events

  // Software may only set the two handshake flags; hardware clears them
  assign wr_reload = i_wr && swd_pkg::swd_hit(i_addr, swd_pkg::ADDR_RELOAD);
  assign wr_prio = i_wr && swd_pkg::swd_hit(i_addr, swd_pkg::ADDR_PRIO0);
  assign wr_irq_enable_0 = i_wr && swd_pkg::swd_hit(i_addr, swd_pkg::ADDR_IRQ_ENABLE_0);
  assign wr_irq_enable_1 = i_wr && swd_pkg::swd_hit(i_addr, swd_pkg::ADDR_IRQ_ENABLE_1);
  assign set_refresh = wr_irq_enable_0 && i_wdata[swd_pkg::BIT_REFRESH];
  assign set_start = wr_irq_enable_1 && i_wdata[swd_pkg::BIT_START];
  assign do_refresh = set_start && refresh_flag;

  // Refresh flag: dropped early when the refresh it arms is taken
  swd_flag_timer u_refresh_flag (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_set(set_refresh),
    .i_clear(do_refresh),
    .o_flag(refresh_flag)
  );

  // Start flag: only times out, never dropped early
  swd_flag_timer u_start_flag (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_set(set_start),
    .i_clear(1'b0),
    .o_flag(start_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler

  // Prescaler runs only while the watchdog runs; a refresh restarts it
  assign pre_bus.run = (state_ff == swd_pkg::ST_RUN);
  assign pre_bus.clear = do_refresh;
  assign pre_bus.sel_long = reload_ff[swd_pkg::BIT_PRESCALE_SEL];

  // Divider that paces the counter
  swd_prescaler u_prescaler (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .pre(pre_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog core

  // Run state; only the internal reset brings it back to idle
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      swd_pkg::ST_IDLE: begin
        if (set_start) begin
          nxt_state = swd_pkg::ST_RUN;
        end
      end
      swd_pkg::ST_RUN: begin
        nxt_state = swd_pkg::ST_RUN;
      end
      default: begin
        nxt_state = swd_pkg::ST_IDLE;
      end
    endcase
    nxt_running = (nxt_state == swd_pkg::ST_RUN);
  end

  // Register run state; the running flag has its own flop to drive the pin
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_ff <= swd_pkg::ST_IDLE;
      running_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      running_ff <= nxt_running;
    end
  end

  // Counter; a refresh reload wins over a prescaler tick
  always_comb begin
    nxt_count = count_ff;
    if (do_refresh) begin
      nxt_count = {1'b0, reload_ff[6:0], 8'h00};
    end else if (state_ff == swd_pkg::ST_RUN && pre_bus.tick) begin
      nxt_count = count_ff + 16'h0001;
    end
  end

  // Register counter
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      count_ff <= swd_pkg::RST_COUNT;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // Expiry follows the counter, so any move off the expiry value drops it
  always_comb begin
    nxt_expired = (count_ff == swd_pkg::EXPIRY_COUNT);
    nxt_reset_req = nxt_expired;
  end

  // Register expiry status and reset request
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      expired_ff <= 1'b0;
      reset_req_ff <= 1'b0;
    end else begin
      expired_ff <= nxt_expired;
      reset_req_ff <= nxt_reset_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expiry record in the priority register

  // Hardware set wins over a software clear
  always_comb begin
    nxt_prio_expired = prio_expired_ff;
    if (wr_prio) begin
      if (!i_wdata[swd_pkg::BIT_EXPIRED]) begin
        nxt_prio_expired = 1'b0;
      end
    end
    if (expired_ff) begin
      nxt_prio_expired = 1'b1;
    end
  end

  // Of the two resets only power-on reset clears the record, so it survives the watchdog reset
  always_ff @(posedge i_clock) begin
    if (i_por_rst) begin
      prio_expired_ff <= 1'b0;
    end else begin
      prio_expired_ff <= nxt_prio_expired;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  // Reload value and plain priority bits
  always_comb begin
    nxt_reload = reload_ff;
    nxt_prio_low = prio_low_ff;
    if (wr_reload) begin
      nxt_reload = i_wdata;
    end
    if (wr_prio) begin
      nxt_prio_low = i_wdata[5:0];
    end
  end

  // Register reload value and plain priority bits
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      reload_ff <= swd_pkg::RST_BYTE;
      prio_low_ff <= 6'h00;
    end else begin
      reload_ff <= nxt_reload;
      prio_low_ff <= nxt_prio_low;
    end
  end

  // Interrupt enable bits; the flag bits live in the flag timers
  always_comb begin
    nxt_irq_enable_0 = irq_enable_0_ff;
    nxt_irq_enable_1 = irq_enable_1_ff;
    if (wr_irq_enable_0) begin
      nxt_irq_enable_0 = {i_wdata[swd_pkg::BIT_GLOBAL_GATE], 1'b0, i_wdata[4:0]};
    end
    if (wr_irq_enable_1) begin
      nxt_irq_enable_1 = i_wdata[5:1];
    end
  end

  // Register interrupt enable bits
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      irq_enable_0_ff <= 7'h00;
      irq_enable_1_ff <= 5'h00;
    end else begin
      irq_enable_0_ff <= nxt_irq_enable_0;
      irq_enable_1_ff <= nxt_irq_enable_1;
    end
  end

  // Read mux; data stand only in the cycle after the strobe
  always_comb begin
    nxt_rdata = swd_pkg::RST_BYTE;
    if (i_rd) begin
      case (1'b1)
        swd_pkg::swd_hit(i_addr, swd_pkg::ADDR_RELOAD): nxt_rdata = reload_ff;
        swd_pkg::swd_hit(i_addr, swd_pkg::ADDR_IRQ_ENABLE_0): begin
          nxt_rdata = {irq_enable_0_ff[6], refresh_flag, 1'b0, irq_enable_0_ff[4:0]};
        end
        swd_pkg::swd_hit(i_addr, swd_pkg::ADDR_IRQ_ENABLE_1): begin
          nxt_rdata = {1'b0, start_flag, irq_enable_1_ff, 1'b0};
        end
        swd_pkg::swd_hit(i_addr, swd_pkg::ADDR_PRIO0): begin
          nxt_rdata = {1'b0, prio_expired_ff, prio_low_ff};
        end
        swd_pkg::swd_hit(i_addr, swd_pkg::ADDR_CNT_LO): nxt_rdata = count_ff[7:0];
        swd_pkg::swd_hit(i_addr, swd_pkg::ADDR_CNT_HI): nxt_rdata = count_ff[15:8];
        default: nxt_rdata = swd_pkg::RST_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt gating

  // Source order: ext0, timer0, ext1, timer1, serial0, ext2..ext6
  assign irq_enable = {irq_enable_1_ff, irq_enable_0_ff[4:0]};

  // One gate per source, all behind the global gate
  genvar g;
  generate
    for (g = 0; g < swd_pkg::NUM_IRQ; g++) begin : g_gate
      assign nxt_irq[g] = i_irq_req[g] && irq_enable[g] && irq_enable_0_ff[6];
    end
  endgenerate

  // Register gated requests, one cycle behind the sources
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      irq_ff <= '0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // Register read data; cycles without a read show zero
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rdata_ff <= swd_pkg::RST_BYTE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Every output comes straight from a register
  assign o_rdata = rdata_ff;
  assign o_irq_gated = irq_ff;
  assign o_wd_expired_status = expired_ff;
  assign o_chip_reset_req = reset_req_ff;
  assign o_wd_running = running_ff;

endmodule // swd_watchdog

// File: testbench/swd_asserts.sv
`timescale 1ns/100ps
module swd_asserts (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_por_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [swd_pkg::NUM_IRQ-1:0] i_irq_req,
  input wire logic [7:0] o_rdata,
  input wire logic [swd_pkg::NUM_IRQ-1:0] o_irq_gated,
  input wire logic o_wd_expired_status,
  input wire logic o_chip_reset_req,
  input wire logic o_wd_running
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic gate_ff;
  logic nxt_gate;
  ////////////////////////////////////////////////////////////////
  // Shadow of the global interrupt gate bit
  always_comb begin
    nxt_gate = gate_ff;
    if (i_wr && i_addr == swd_pkg::ADDR_IRQ_ENABLE_0) begin
      nxt_gate = i_wdata[7];
    end
  end
  always_ff @(posedge i_clock) begin
    gate_ff <= i_rst ? 1'h0 : nxt_gate;
  end
  ////////////////////////////////////////////////////////////////
  // Steps of a start write and of a status read
  sequence s_start_wr;
    i_wr && i_addr == swd_pkg::ADDR_IRQ_ENABLE_1 && i_wdata[6];
  endsequence
  sequence s_prio_rd;
    o_wd_expired_status ##1 (o_wd_expired_status && i_rd && i_addr == swd_pkg::ADDR_PRIO0);
  endsequence
  AST_START: assert property (s_start_wr |=> o_wd_running)
    else $error("start write did not run the watchdog");
  AST_RUN_HOLD: assert property (o_wd_running && !i_rst |=> o_wd_running)
    else $error("watchdog stopped without reset");
  AST_RESET_CLEAR: assert property (disable iff (1'h0)
    i_rst |=> !o_wd_running && !o_wd_expired_status && o_irq_gated == '0)
    else $error("reset left watchdog outputs active");
  AST_PAIR: assert property (o_wd_expired_status == o_chip_reset_req)
    else $error("reset request differs from expiry status");
  AST_PRIO: assert property (s_prio_rd |=> o_rdata[6])
    else $error("expiry record not set in priority register");
  AST_EXPIRE_RUN: assert property ($rose(o_wd_expired_status) |-> o_wd_running)
    else $error("expiry while idle");
  AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
  AST_GATE_OFF: assert property (!$past(gate_ff) |-> o_irq_gated == '0)
    else $error("interrupt passed with global gate off");
  AST_GATE_SUB: assert property ((o_irq_gated & ~$past(i_irq_req)) == '0)
    else $error("interrupt passed without request");
endmodule // swd_asserts
bind swd_watchdog swd_asserts u_chk (.i_clock, .i_rst, .i_por_rst, .i_addr, .i_wdata,
  .i_wr, .i_rd, .i_irq_req, .o_rdata, .o_irq_gated, .o_wd_expired_status,
  .o_chip_reset_req, .o_wd_running);

// File: testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic i_clock = 1'h0;
  logic i_rst = 1'h1;
  logic i_por_rst = 1'h1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'h0;
  logic i_rd = 1'h0;
  logic [9:0] i_irq_req = 10'h000;
  logic [7:0] o_rdata;
  logic [9:0] o_irq_gated;
  logic o_wd_expired_status;
  logic o_chip_reset_req;
  logic o_wd_running;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  logic [31:0] seed = 32'h000118D2;
  logic [7:0] rv;
  logic [15:0] cnt;
  logic [7:0] e0;
  logic [7:0] e1;
  logic [7:0] regs [7] = '{8'h86, 8'hA8, 8'hA9, 8'hB8, 8'hF0, 8'hF1, 8'h00};
  swd_watchdog dut (.i_clock, .i_rst, .i_por_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .i_irq_req, .o_rdata, .o_irq_gated, .o_wd_expired_status, .o_chip_reset_req,
    .o_wd_running);
  ////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #50 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [9:0] gexp(input logic [9:0] r, input logic [7:0] a,
    input logic [7:0] b);
    return a[7] ? (r & {b[5:1], a[4:0]}) : 10'h000;
  endfunction
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clock);
    i_rd <= 1'h1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'h0;
    #1 rv = o_rdata;
  endtask
  task automatic rc(input string s, input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(s, 16'(e), 16'(rv));
  endtask
  task automatic rdcnt();
    rd(swd_pkg::ADDR_CNT_LO);
    cnt[7:0] = rv;
    rd(swd_pkg::ADDR_CNT_HI);
    cnt[15:8] = rv;
  endtask
  task automatic refresh(input logic [7:0] r);
    wr(swd_pkg::ADDR_RELOAD, r);
    wr(swd_pkg::ADDR_IRQ_ENABLE_0, 8'h40);
    wr(swd_pkg::ADDR_IRQ_ENABLE_1, 8'h40);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge i_clock);
    i_rst <= 1'h0;
    i_por_rst <= 1'h0;
    foreach (regs[k]) rc("reset", regs[k], 8'h00);
    for (int k = 0; k < 24; k++) begin
      seed = xs(seed);
      if (k % 4 == 0) begin
        e0 = (k == 4) ? 8'h1F : seed[7:0] & 8'hBF;
        e1 = (k == 4) ? 8'h3E : seed[15:8] & 8'hBF;
        wr(swd_pkg::ADDR_IRQ_ENABLE_0, e0);
        wr(swd_pkg::ADDR_IRQ_ENABLE_1, e1);
        rc("en0", swd_pkg::ADDR_IRQ_ENABLE_0, e0 & 8'h9F);
        rc("en1", swd_pkg::ADDR_IRQ_ENABLE_1, e1 & 8'h3E);
      end
      @(posedge i_clock);
      i_irq_req <= seed[25:16];
      repeat (2) @(posedge i_clock);
      #1 chk("gated", 16'(gexp(seed[25:16], e0, e1)), 16'(o_irq_gated));
    end
    wr(swd_pkg::ADDR_PRIO0, 8'hFF);
    rc("prio", swd_pkg::ADDR_PRIO0, 8'h3F);
    wr(swd_pkg::ADDR_IRQ_ENABLE_0, 8'h40);
    rc("wd_on", swd_pkg::ADDR_IRQ_ENABLE_0, 8'h40);
    repeat (12) @(posedge i_clock);
    rc("wd_off", swd_pkg::ADDR_IRQ_ENABLE_0, 8'h00);
    chk("idle", 16'h0000, 16'(o_wd_running));
    wr(swd_pkg::ADDR_IRQ_ENABLE_1, 8'h40);
    rc("sw_on", swd_pkg::ADDR_IRQ_ENABLE_1, 8'h40);
    chk("run", 16'h0001, 16'(o_wd_running));
    repeat (12) @(posedge i_clock);
    rc("sw_off", swd_pkg::ADDR_IRQ_ENABLE_1, 8'h00);
    refresh(8'h05);
    rc("wd_clr", swd_pkg::ADDR_IRQ_ENABLE_0, 8'h00);
    repeat (81) @(posedge i_clock);
    rdcnt();
    chk("count", 16'h0503, cnt);
    wr(swd_pkg::ADDR_IRQ_ENABLE_1, 8'h00);
    wr(swd_pkg::ADDR_IRQ_ENABLE_0, 8'h40);
    repeat (13) @(posedge i_clock);
    wr(swd_pkg::ADDR_IRQ_ENABLE_1, 8'h40);
    rdcnt();
    chk("noreload", 16'h0001, 16'(cnt > 16'h0503 && cnt < 16'h0600));
    chk("still", 16'h0001, 16'(o_wd_running));
    refresh(8'h83);
    repeat (779) @(posedge i_clock);
    rdcnt();
    chk("long", 16'h0302, cnt);
    refresh(8'h7C);
    n = 0;
    while (!o_wd_expired_status && n < 7000) begin
      @(posedge i_clock);
      #1 n++;
    end
    chk("exp_time", 16'h0001, 16'(n > 6100 && n < 6150));
    chk("rst_req", 16'h0001, 16'(o_chip_reset_req));
    rc("prio_set", swd_pkg::ADDR_PRIO0, 8'h7F);
    repeat (30) @(posedge i_clock);
    #1 chk("exp_drop", 16'h0000, 16'(o_wd_expired_status));
    i_rst <= 1'h1;
    @(posedge i_clock);
    i_rst <= 1'h0;
    @(posedge i_clock);
    #1 chk("stop", 16'h0000, 16'(o_wd_running));
    rc("prio_keep", swd_pkg::ADDR_PRIO0, 8'h40);
    wr(swd_pkg::ADDR_PRIO0, 8'h00);
    rc("prio_clr", swd_pkg::ADDR_PRIO0, 8'h00);
    rdcnt();
    chk("cnt_rst", 16'h0000, cnt);
    results();
  end
endmodule // testbench
